// file: core/dcs_addr_guard.sv
module dcs_addr_guard #(
	parameter logic [15:0] RAM_BASE = 16'h2000,
	parameter logic [15:0] RAM_BYTES = 16'h0800
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	dcs_map_if.grd_end g
);
	logic [16:0] step;
	logic [16:0] sum;
	logic [16:0] lim;

	// element index steps by one byte or one word; the count stays in elements
	assign step = g.byte_mode ? {7'h00, g.idx} : {6'h00, g.idx, 1'b0};
	assign sum = {1'b0, RAM_BASE} + {1'b0, g.off} + step;
	assign lim = {1'b0, RAM_BASE} + {1'b0, RAM_BYTES};
	assign g.ram_addr = sum[15:0];
	// words only at even addresses; anything past the region is refused
	assign g.ram_ok = (sum < lim) && (g.byte_mode || !sum[0]);
	always_comb begin
		case (g.pad)
			dcs_pkg::PA_CAPTURE_ONE_BUFFER, dcs_pkg::PA_COMPARE_ONE_SECONDARY,
			dcs_pkg::PA_COMPARE_ONE_PRIMARY, dcs_pkg::PA_UART_ONE_TX_DATA,
			dcs_pkg::PA_UART_ONE_RX_DATA, dcs_pkg::PA_SERIAL_ONE_BUFFER,
			dcs_pkg::PA_CONVERTER_RESULT_ZERO, dcs_pkg::PA_PARALLEL_PORT_DATA: g.pad_ok = 1'b1;
			default: g.pad_ok = 1'b0;
		endcase
	end

	chk_ram_in_region: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		g.ram_ok |-> (g.ram_addr >= RAM_BASE) && ({1'b0, g.ram_addr} < lim))
		else $error("ram address accepted outside region");
	chk_ram_offset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(g.idx == 10'h000 && !sum[16]) |-> (g.ram_addr == RAM_BASE + g.off))
		else $error("first element not at base plus offset");
endmodule

// file: core/dcs_map_if.sv
interface dcs_map_if #(parameter int NCH = 8);
	logic [dcs_pkg::CODE_W-1:0] req_code [NCH];
	logic [NCH-1:0] hit;
	logic [15:0] off;
	logic [dcs_pkg::CNT_W-1:0] idx;
	logic byte_mode;
	logic [15:0] pad;
	logic [15:0] ram_addr;
	logic ram_ok;
	logic pad_ok;
	modport map_end (input req_code, output hit);
	modport map_use (output req_code, input hit);
	modport grd_end (input off, idx, byte_mode, pad, output ram_addr, ram_ok, pad_ok);
	modport grd_use (output off, idx, byte_mode, pad, input ram_addr, ram_ok, pad_ok);
endinterface

// file: core/dcs_pkg.sv
package dcs_pkg;
	localparam int CODE_W = 7;
	localparam int CNT_W = 10;
	localparam int N_SRC = 10;
	// request line index on the request input vector
	localparam int SRC_EXT_IRQ_ZERO = 0;
	localparam int SRC_CAPTURE_ONE = 1;
	localparam int SRC_COMPARE_ONE = 2;
	localparam int SRC_TIMER_TWO = 3;
	localparam int SRC_TIMER_THREE = 4;
	localparam int SRC_SERIAL_ONE = 5;
	localparam int SRC_UART_ONE_RX = 6;
	localparam int SRC_UART_ONE_TX = 7;
	localparam int SRC_CONVERTER = 8;
	localparam int SRC_PARALLEL = 9;
	// request source codes
	localparam logic [6:0] CODE_EXT_IRQ_ZERO = 7'h00;
	localparam logic [6:0] CODE_CAPTURE_ONE = 7'h01;
	localparam logic [6:0] CODE_COMPARE_ONE = 7'h02;
	localparam logic [6:0] CODE_TIMER_TWO = 7'h07;
	localparam logic [6:0] CODE_TIMER_THREE = 7'h08;
	localparam logic [6:0] CODE_SERIAL_ONE = 7'h0A;
	localparam logic [6:0] CODE_UART_ONE_RX = 7'h0B;
	localparam logic [6:0] CODE_UART_ONE_TX = 7'h0C;
	localparam logic [6:0] CODE_CONVERTER = 7'h0D;
	localparam logic [6:0] CODE_PARALLEL = 7'h2D;
	// peripheral data register addresses
	localparam logic [15:0] PA_CAPTURE_ONE_BUFFER = 16'h0140;
	localparam logic [15:0] PA_COMPARE_ONE_SECONDARY = 16'h0180;
	localparam logic [15:0] PA_COMPARE_ONE_PRIMARY = 16'h0182;
	localparam logic [15:0] PA_UART_ONE_TX_DATA = 16'h0224;
	localparam logic [15:0] PA_UART_ONE_RX_DATA = 16'h0226;
	localparam logic [15:0] PA_SERIAL_ONE_BUFFER = 16'h0248;
	localparam logic [15:0] PA_CONVERTER_RESULT_ZERO = 16'h0300;
	localparam logic [15:0] PA_PARALLEL_PORT_DATA = 16'h0608;
	// register map: byte address bits [7:5] channel, [4:2] register
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_REQ = 3'h1;
	localparam logic [2:0] REG_PAD = 3'h2;
	localparam logic [2:0] REG_STA = 3'h3;
	localparam logic [2:0] REG_STB = 3'h4;
	localparam logic [2:0] REG_CNT = 3'h5;
	localparam logic [2:0] REG_STAT = 3'h6;
	localparam logic [11:0] ADDR_DONE = 12'h100;
	// control register fields
	localparam int CTRL_W = 4;
	localparam int CTRL_EN = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_BYTE = 2;
	localparam int CTRL_PP = 3;
	localparam int CTRL_FORCE = 4;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [6:0] REQ_RST = 7'h00;
	localparam logic [15:0] WORD16_RST = 16'h0000;
	localparam logic [9:0] CNT_RST = 10'h000;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dcs_state_t;
endpackage

// file: core/dcs_src_map.sv
module dcs_src_map #(parameter int NCH = 8) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [dcs_pkg::N_SRC-1:0] req_line_in,
	dcs_map_if.map_end m
);
	function automatic logic line_of(input logic [6:0] code, input logic [9:0] lines);
		case (code)
			dcs_pkg::CODE_EXT_IRQ_ZERO: line_of = lines[dcs_pkg::SRC_EXT_IRQ_ZERO];
			dcs_pkg::CODE_CAPTURE_ONE: line_of = lines[dcs_pkg::SRC_CAPTURE_ONE];
			dcs_pkg::CODE_COMPARE_ONE: line_of = lines[dcs_pkg::SRC_COMPARE_ONE];
			dcs_pkg::CODE_TIMER_TWO: line_of = lines[dcs_pkg::SRC_TIMER_TWO];
			dcs_pkg::CODE_TIMER_THREE: line_of = lines[dcs_pkg::SRC_TIMER_THREE];
			dcs_pkg::CODE_SERIAL_ONE: line_of = lines[dcs_pkg::SRC_SERIAL_ONE];
			dcs_pkg::CODE_UART_ONE_RX: line_of = lines[dcs_pkg::SRC_UART_ONE_RX];
			dcs_pkg::CODE_UART_ONE_TX: line_of = lines[dcs_pkg::SRC_UART_ONE_TX];
			dcs_pkg::CODE_CONVERTER: line_of = lines[dcs_pkg::SRC_CONVERTER];
			dcs_pkg::CODE_PARALLEL: line_of = lines[dcs_pkg::SRC_PARALLEL];
			default: line_of = 1'b0;
		endcase
	endfunction

	for (genvar c = 0; c < NCH; c++) begin : g_map
		assign m.hit[c] = line_of(m.req_code[c], req_line_in);
	end

	chk_timer_two_map: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(m.req_code[0] == dcs_pkg::CODE_TIMER_TWO) |-> (m.hit[0] == req_line_in[3]))
		else $error("timer two code does not follow its line");
	chk_unused_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(m.req_code[0] == 7'h7F) |-> !m.hit[0])
		else $error("unused request code triggered a channel");
endmodule

// file: core/dcs_top.sv
// How it works
// - channel holds peripheral address and request select
// - codes pick ext irq, timer two, three
// - capture one and compare one codes, addresses
// - serial one code and buffer address
// - uart one receive and transmit codes, addresses
// - parallel port and converter codes, addresses
// - shared request pends both; priority serves first
// - unknown peripheral address: drop writes, read zero
// - start values A and B are offsets
// - offset outside region: drop writes, read zero
// - block completes after count plus one requests
// - count is elements, byte or word alike
// - count past region: drop writes, read zero
// - only data requests; errors left to peripheral
module dcs_top #(
	parameter int NCH = 8,
	parameter logic [15:0] RAM_BASE = 16'h2000,
	parameter logic [15:0] RAM_BYTES = 16'h0800
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic [dcs_pkg::N_SRC-1:0] req_line_in,
	output logic [15:0] per_addr_out,
	output logic per_rd_out,
	output logic per_wr_out,
	input wire logic [15:0] per_rdata_in,
	output logic [15:0] ram_addr_out,
	output logic ram_rd_out,
	output logic ram_wr_out,
	input wire logic [15:0] ram_rdata_in,
	output logic [15:0] xfer_wdata_out,
	output logic xfer_byte_out,
	output logic [NCH-1:0] block_done_out
);
	localparam int CH_W = 3;

	if (NCH < 1 || NCH > 8) begin : g_bad_nch
		$error("NCH must be 1 to 8");
	end
	if ({1'b0, RAM_BASE} + {1'b0, RAM_BYTES} > 17'h10000) begin : g_bad_ram
		$error("ram region runs past the 16-bit space");
	end

	dcs_map_if #(.NCH(NCH)) m ();

	// per-channel setup and state
	logic [dcs_pkg::CTRL_W-1:0] ctrl_q [NCH];
	logic [6:0] req_q [NCH];
	logic [15:0] pad_q [NCH];
	logic [15:0] sta_q [NCH];
	logic [15:0] stb_q [NCH];
	logic [9:0] cnt_q [NCH];
	logic [9:0] idx_q [NCH];
	logic [NCH-1:0] bsel_q;
	logic [NCH-1:0] pend_q;
	logic [NCH-1:0] done_q;

	// bus slave state
	logic wr_pend_q, wr_pend_d;
	logic rd_wait_q, rd_wait_d;
	logic a_ok_q, a_ok_d;
	logic [11:0] a_addr_q, a_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q, hreadyout_d;
	logic hresp_q;
	logic ahb_go;
	logic wr_apply;
	logic wr_glob;
	logic [CH_W-1:0] wr_ch;
	logic [2:0] wr_reg;

	// transfer sequencer state
	dcs_pkg::dcs_state_t state_q, state_d;
	logic [CH_W-1:0] act_q, act_d;
	logic [15:0] per_addr_q, per_addr_d;
	logic per_rd_q, per_rd_d;
	logic per_wr_q, per_wr_d;
	logic [15:0] ram_addr_q, ram_addr_d;
	logic ram_rd_q, ram_rd_d;
	logic ram_wr_q, ram_wr_d;
	logic [15:0] wdata_q, wdata_d;
	logic byte_q, byte_d;
	logic grant_any;
	logic [CH_W-1:0] grant_ch;
	logic [CH_W-1:0] sel_ch;
	logic svc_end;
	logic ram_ok_seen_q;

	dcs_src_map #(.NCH(NCH)) u_map (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.req_line_in(req_line_in),
		.m(m.map_end)
	);

	dcs_addr_guard #(.RAM_BASE(RAM_BASE), .RAM_BYTES(RAM_BYTES)) u_guard (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.g(m.grd_end)
	);

	// ---------------- bus slave ----------------
	assign ahb_go = hsel_in && htrans_in[1] && hready_in;
	assign wr_apply = wr_pend_q && a_ok_q;
	assign wr_glob = a_addr_q[8];
	assign wr_ch = a_addr_q[7:5];
	assign wr_reg = a_addr_q[4:2];

	always_comb begin
		wr_pend_d = 1'b0;
		rd_wait_d = 1'b0;
		a_ok_d = a_ok_q;
		a_addr_d = a_addr_q;
		hrdata_d = hrdata_q;
		hreadyout_d = 1'b1;
		if (ahb_go) begin
			a_addr_d = haddr_in[11:0];
			a_ok_d = (haddr_in[31:12] == 20'h00000) && (haddr_in[11:9] == 3'h0)
				&& (haddr_in[8] ? (haddr_in[7:2] == 6'h00) : (haddr_in[7:5] < NCH));
			wr_pend_d = hwrite_in;
			rd_wait_d = !hwrite_in;
			// reads take one wait so a write just ahead is already visible
			hreadyout_d = hwrite_in;
		end
		if (rd_wait_q) begin
			hrdata_d = 32'h0000_0000;
			if (a_ok_q && wr_glob) begin
				hrdata_d[NCH-1:0] = done_q;
			end else if (a_ok_q) begin
				case (wr_reg)
					dcs_pkg::REG_CTRL: hrdata_d[3:0] = ctrl_q[wr_ch];
					dcs_pkg::REG_REQ: hrdata_d[6:0] = req_q[wr_ch];
					dcs_pkg::REG_PAD: hrdata_d[15:0] = pad_q[wr_ch];
					dcs_pkg::REG_STA: hrdata_d[15:0] = sta_q[wr_ch];
					dcs_pkg::REG_STB: hrdata_d[15:0] = stb_q[wr_ch];
					dcs_pkg::REG_CNT: hrdata_d[9:0] = cnt_q[wr_ch];
					dcs_pkg::REG_STAT: hrdata_d[12:0] = {done_q[wr_ch], pend_q[wr_ch],
						bsel_q[wr_ch], idx_q[wr_ch]};
					default: hrdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
			a_ok_q <= 1'b0;
			a_addr_q <= 12'h000;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_wait_q <= rd_wait_d;
			a_ok_q <= a_ok_d;
			a_addr_q <= a_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= hreadyout_d;
			hresp_q <= 1'b0;
		end
	end

	// ---------------- per-channel setup ----------------
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam logic [CH_W-1:0] C_IDX = CH_W'(c);
		logic [dcs_pkg::CTRL_W-1:0] ctrl_d;
		logic [6:0] req_d;
		logic [15:0] pad_d, sta_d, stb_d;
		logic [9:0] cnt_d, idx_d;
		logic bsel_d, pend_d, done_d;
		logic me_wr, me_svc;

		assign me_wr = wr_apply && !wr_glob && (wr_ch == C_IDX);
		assign me_svc = svc_end && (act_q == C_IDX);
		assign m.req_code[c] = req_q[c];

		always_comb begin
			ctrl_d = ctrl_q[c];
			req_d = req_q[c];
			pad_d = pad_q[c];
			sta_d = sta_q[c];
			stb_d = stb_q[c];
			cnt_d = cnt_q[c];
			idx_d = idx_q[c];
			bsel_d = bsel_q[c];
			pend_d = pend_q[c];
			done_d = done_q[c];
			if (me_wr) begin
				case (wr_reg)
					dcs_pkg::REG_CTRL: begin
						ctrl_d = hwdata_in[3:0];
						// fresh setup starts at the first element of buffer A
						idx_d = dcs_pkg::CNT_RST;
						bsel_d = 1'b0;
					end
					dcs_pkg::REG_REQ: req_d = hwdata_in[6:0];
					dcs_pkg::REG_PAD: pad_d = hwdata_in[15:0];
					dcs_pkg::REG_STA: sta_d = hwdata_in[15:0];
					dcs_pkg::REG_STB: stb_d = hwdata_in[15:0];
					dcs_pkg::REG_CNT: cnt_d = hwdata_in[9:0];
					default: ;
				endcase
			end
			if (wr_apply && wr_glob && hwdata_in[c]) begin
				done_d = 1'b0;
			end
			if (me_svc) begin
				if (idx_q[c] == cnt_q[c]) begin
					idx_d = dcs_pkg::CNT_RST;
					done_d = 1'b1;
					if (ctrl_q[c][dcs_pkg::CTRL_PP]) begin
						bsel_d = !bsel_q[c];
					end else begin
						ctrl_d[dcs_pkg::CTRL_EN] = 1'b0;
					end
				end else begin
					idx_d = idx_q[c] + 10'h001;
				end
			end
			if (grant_any && state_q == dcs_pkg::ST_IDLE && grant_ch == C_IDX) begin
				pend_d = 1'b0;
			end
			// a new request in the grant cycle is kept, not lost
			if ((ctrl_q[c][dcs_pkg::CTRL_EN] && m.hit[c])
				|| (me_wr && wr_reg == dcs_pkg::REG_CTRL && hwdata_in[dcs_pkg::CTRL_FORCE])) begin
				pend_d = 1'b1;
			end
		end

		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				ctrl_q[c] <= dcs_pkg::CTRL_RST;
				req_q[c] <= dcs_pkg::REQ_RST;
				pad_q[c] <= dcs_pkg::WORD16_RST;
				sta_q[c] <= dcs_pkg::WORD16_RST;
				stb_q[c] <= dcs_pkg::WORD16_RST;
				cnt_q[c] <= dcs_pkg::CNT_RST;
				idx_q[c] <= dcs_pkg::CNT_RST;
				bsel_q[c] <= 1'b0;
				pend_q[c] <= 1'b0;
				done_q[c] <= 1'b0;
			end else begin
				ctrl_q[c] <= ctrl_d;
				req_q[c] <= req_d;
				pad_q[c] <= pad_d;
				sta_q[c] <= sta_d;
				stb_q[c] <= stb_d;
				cnt_q[c] <= cnt_d;
				idx_q[c] <= idx_d;
				bsel_q[c] <= bsel_d;
				pend_q[c] <= pend_d;
				done_q[c] <= done_d;
			end
		end
	end

	// ---------------- arbitration and transfer ----------------
	always_comb begin
		grant_any = 1'b0;
		grant_ch = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend_q[i] && ctrl_q[i][dcs_pkg::CTRL_EN]) begin
				grant_any = 1'b1;
				grant_ch = CH_W'(i);
			end
		end
	end

	assign sel_ch = (state_q == dcs_pkg::ST_IDLE) ? grant_ch : act_q;
	assign m.off = bsel_q[sel_ch] ? stb_q[sel_ch] : sta_q[sel_ch];
	assign m.idx = idx_q[sel_ch];
	assign m.byte_mode = ctrl_q[sel_ch][dcs_pkg::CTRL_BYTE];
	assign m.pad = pad_q[sel_ch];
	assign svc_end = (state_q == dcs_pkg::ST_WRITE);

	always_comb begin
		state_d = state_q;
		act_d = act_q;
		per_addr_d = per_addr_q;
		per_rd_d = 1'b0;
		per_wr_d = 1'b0;
		ram_addr_d = ram_addr_q;
		ram_rd_d = 1'b0;
		ram_wr_d = 1'b0;
		wdata_d = wdata_q;
		byte_d = byte_q;
		case (state_q)
			dcs_pkg::ST_IDLE: begin
				if (grant_any) begin
					state_d = dcs_pkg::ST_READ;
					act_d = grant_ch;
					byte_d = m.byte_mode;
					per_addr_d = m.pad;
					ram_addr_d = m.ram_addr;
					if (ctrl_q[grant_ch][dcs_pkg::CTRL_DIR]) begin
						ram_rd_d = m.ram_ok;
					end else begin
						per_rd_d = m.pad_ok;
					end
				end
			end
			dcs_pkg::ST_READ: begin
				state_d = dcs_pkg::ST_WRITE;
				// refused reads give zero
				if (ctrl_q[act_q][dcs_pkg::CTRL_DIR]) begin
					wdata_d = ram_rd_q ? ram_rdata_in : 16'h0000;
					per_wr_d = m.pad_ok;
				end else begin
					wdata_d = per_rd_q ? per_rdata_in : 16'h0000;
					ram_wr_d = m.ram_ok;
				end
			end
			dcs_pkg::ST_WRITE: state_d = dcs_pkg::ST_IDLE;
			default: state_d = dcs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_q <= dcs_pkg::ST_IDLE;
			act_q <= '0;
			per_addr_q <= 16'h0000;
			per_rd_q <= 1'b0;
			per_wr_q <= 1'b0;
			ram_addr_q <= 16'h0000;
			ram_rd_q <= 1'b0;
			ram_wr_q <= 1'b0;
			wdata_q <= 16'h0000;
			byte_q <= 1'b0;
			ram_ok_seen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			act_q <= act_d;
			per_addr_q <= per_addr_d;
			per_rd_q <= per_rd_d;
			per_wr_q <= per_wr_d;
			ram_addr_q <= ram_addr_d;
			ram_rd_q <= ram_rd_d;
			ram_wr_q <= ram_wr_d;
			wdata_q <= wdata_d;
			byte_q <= byte_d;
			ram_ok_seen_q <= m.ram_ok;
		end
	end

	assign hrdata_out = hrdata_q;
	assign hreadyout_out = hreadyout_q;
	assign hresp_out = hresp_q;
	assign per_addr_out = per_addr_q;
	assign per_rd_out = per_rd_q;
	assign per_wr_out = per_wr_q;
	assign ram_addr_out = ram_addr_q;
	assign ram_rd_out = ram_rd_q;
	assign ram_wr_out = ram_wr_q;
	assign xfer_wdata_out = wdata_q;
	assign xfer_byte_out = byte_q;
	assign block_done_out = done_q;

	// ---------------- checks ----------------
	chk_pend_on_hit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(ctrl_q[0][dcs_pkg::CTRL_EN] && m.hit[0]) |=> pend_q[0])
		else $error("enabled channel lost its request");
	chk_shared_source: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == dcs_pkg::ST_IDLE && pend_q[0] && ctrl_q[0][dcs_pkg::CTRL_EN]
		&& pend_q[NCH-1] && ctrl_q[NCH-1][dcs_pkg::CTRL_EN] && !m.hit[NCH-1])
		|=> (act_q == '0) ##1 pend_q[NCH-1])
		else $error("priority order or pending state wrong");
	chk_bad_pad_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == dcs_pkg::ST_READ && !ctrl_q[act_q][dcs_pkg::CTRL_DIR] && !per_rd_q)
		|=> (wdata_q == 16'h0000))
		else $error("refused peripheral read did not give zero");
	chk_ram_drop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ram_wr_q |-> ram_ok_seen_q)
		else $error("ram write outside region");
	chk_one_element: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == dcs_pkg::ST_READ && cnt_q[act_q] == 10'h000 && !(wr_apply && wr_glob))
		##1 (state_q == dcs_pkg::ST_WRITE) |=> done_q[$past(act_q, 2)])
		else $error("zero count did not end after one element");
	chk_elem_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(svc_end && act_q == '0 && idx_q[0] != cnt_q[0] && !(wr_apply && wr_ch == '0))
		|=> (idx_q[0] == $past(idx_q[0]) + 10'h001))
		else $error("element index did not step by one");
	chk_read_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(ahb_go && !hwrite_in) |=> !hreadyout_q ##1 hreadyout_q)
		else $error("read answer timing wrong");
	cov_shared: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		(m.hit[0] && m.hit[1] && ctrl_q[0][0] && ctrl_q[1][0]));
	cov_done: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(done_q[0]));
	cov_drop: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		(state_q == dcs_pkg::ST_READ && !m.ram_ok));
endmodule

// file: sim/dcs_far_model.sv
module dcs_far_model (
	input wire logic clk_in,
	input wire logic [15:0] per_addr_in,
	input wire logic per_rd_in,
	input wire logic per_wr_in,
	input wire logic [15:0] ram_addr_in,
	input wire logic ram_rd_in,
	input wire logic ram_wr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] per_rdata_out,
	output logic [15:0] ram_rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] junk_q = 16'h0000;
	logic [31:0] ram_log [$];
	logic [31:0] per_log [$];
	int n_prd = 0;
	int n_rrd = 0;
	// outside a read strobe the data lines wander, so a stale sample shows
	always @(posedge clk_in) begin
		junk_q <= ~junk_q + 16'h1357;
	end
	assign per_rdata_out = per_rd_in ? (per_addr_in ^ 16'hC3C3) : junk_q;
	assign ram_rdata_out = ram_rd_in ? (ram_addr_in ^ 16'h3C3C) : ~junk_q;
	always @(posedge clk_in) begin
		if (ram_wr_in) ram_log.push_back({ram_addr_in, wdata_in});
		if (per_wr_in) per_log.push_back({per_addr_in, wdata_in});
		if (per_rd_in) n_prd++;
		if (ram_rd_in) n_rrd++;
	end
endmodule

// file: sim/dcs_top_tb.sv
module dcs_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] BASE = 16'h2000;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [dcs_pkg::N_SRC-1:0] req = '0;
	logic [31:0] hrdata;
	logic hready, hresp, per_rd, per_wr, ram_rd, ram_wr, xbyte;
	logic [15:0] per_addr, per_rdata, ram_addr, ram_rdata, wdata;
	logic [7:0] done;
	int miscompares = 0;
	int n_compared = 0;
	dcs_top #(.NCH(8), .RAM_BASE(BASE), .RAM_BYTES(16'h0800)) u_dcs_top (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .req_line_in(req), .per_addr_out(per_addr),
		.per_rd_out(per_rd), .per_wr_out(per_wr), .per_rdata_in(per_rdata),
		.ram_addr_out(ram_addr), .ram_rd_out(ram_rd), .ram_wr_out(ram_wr),
		.ram_rdata_in(ram_rdata), .xfer_wdata_out(wdata), .xfer_byte_out(xbyte),
		.block_done_out(done));
	dcs_far_model u_dcs_far_model (
		.clk_in(clk_in), .per_addr_in(per_addr), .per_rd_in(per_rd),
		.per_wr_in(per_wr), .ram_addr_in(ram_addr), .ram_rd_in(ram_rd),
		.ram_wr_in(ram_wr), .wdata_in(wdata), .per_rdata_out(per_rdata),
		.ram_rdata_out(ram_rdata));
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_in); while (hready !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	function automatic logic [31:0] ra(input int ch, input logic [2:0] r);
		return {24'h0, ch[2:0], r, 2'b00};
	endfunction
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(what, exp, x);
		chk("bus response", 32'h0, {31'h0, hresp});
	endtask
	task automatic cfg(input int ch, input logic [6:0] code, input logic [15:0] pad,
		input logic [15:0] sta, input logic [9:0] cnt, input logic [3:0] ctrl);
		wr(ra(ch, dcs_pkg::REG_REQ), {25'h0, code});
		wr(ra(ch, dcs_pkg::REG_PAD), {16'h0, pad});
		wr(ra(ch, dcs_pkg::REG_STA), {16'h0, sta});
		wr(ra(ch, dcs_pkg::REG_CNT), {22'h0, cnt});
		wr(ra(ch, dcs_pkg::REG_CTRL), {28'h0, ctrl});
	endtask
	task automatic clr;
		u_dcs_far_model.ram_log.delete();
		u_dcs_far_model.per_log.delete();
		wr({20'h0, dcs_pkg::ADDR_DONE}, 32'hFF);
	endtask
	// one request per element, as a well-behaved peripheral raises it
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk_in);
			req <= 10'(1) << idx;
			@(posedge clk_in);
			req <= '0;
			repeat (8) @(posedge clk_in);
		end
	endtask
	task automatic t_regs;
		rd_chk("ctrl reset", ra(3, dcs_pkg::REG_CTRL), 32'h0);
		rd_chk("code reset", ra(3, dcs_pkg::REG_REQ), 32'h0);
		rd_chk("count reset", ra(7, dcs_pkg::REG_CNT), 32'h0);
		wr(ra(2, dcs_pkg::REG_PAD), 32'h0248);
		rd_chk("periph addr", ra(2, dcs_pkg::REG_PAD), 32'h0248);
		wr(ra(2, dcs_pkg::REG_REQ), 32'h0B);
		rd_chk("code", ra(2, dcs_pkg::REG_REQ), 32'h0B);
		wr(32'h1C, 32'hFFFF);
		rd_chk("unmapped", 32'h1C, 32'h0);
	endtask
	task automatic t_codes;
		logic [6:0] codes [10] = '{7'h00, 7'h01, 7'h02, 7'h07, 7'h08,
			7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h2D};
		logic [15:0] pads [10] = '{16'h0140, 16'h0140, 16'h0182, 16'h0180, 16'h0140,
			16'h0248, 16'h0226, 16'h0224, 16'h0300, 16'h0608};
		for (int i = 0; i < 10; i++) begin
			clr();
			cfg(i % 8, codes[i], pads[i], 16'(i * 8), 10'h0, 4'h1);
			pulse(i, 1);
			chk("elem", {16'(BASE + i * 8), pads[i] ^ 16'hC3C3},
				u_dcs_far_model.ram_log[0]);
			chk("n elem", 32'h1, u_dcs_far_model.ram_log.size());
			chk("done", 32'h1 << (i % 8), {24'h0, done});
			rd_chk("one-shot off", ra(i % 8, dcs_pkg::REG_CTRL), 32'h0);
		end
	endtask
	task automatic t_nocode;
		clr();
		cfg(0, 7'h03, 16'h0140, 16'h0, 10'h0, 4'h1);
		cfg(1, 7'h01, 16'h0140, 16'h0, 10'h0, 4'h0);
		@(posedge clk_in);
		req <= '1;
		repeat (3) @(posedge clk_in);
		req <= '0;
		repeat (8) @(posedge clk_in);
		chk("no trigger", 32'h0, u_dcs_far_model.ram_log.size());
		wr(ra(0, dcs_pkg::REG_CTRL), 32'h0);
	endtask
	task automatic t_badpad;
		int n;
		clr();
		n = u_dcs_far_model.n_prd;
		cfg(0, 7'h07, 16'h0142, 16'h0, 10'h0, 4'h1);
		pulse(3, 1);
		chk("bad pad read", {BASE, 16'h0}, u_dcs_far_model.ram_log[0]);
		chk("no periph rd", n, u_dcs_far_model.n_prd);
		cfg(0, 7'h07, 16'h0142, 16'h0, 10'h0, 4'h3);
		pulse(3, 1);
		chk("bad pad write", 32'h0, u_dcs_far_model.per_log.size());
	endtask
	task automatic t_region;
		int n;
		clr();
		n = u_dcs_far_model.n_rrd;
		cfg(0, 7'h08, 16'h0224, 16'h07FE, 10'h1, 4'h3);
		pulse(4, 2);
		chk("last in", {16'h0224, 16'h27FE ^ 16'h3C3C}, u_dcs_far_model.per_log[0]);
		chk("past end", {16'h0224, 16'h0}, u_dcs_far_model.per_log[1]);
		chk("ram reads", n + 1, u_dcs_far_model.n_rrd);
		cfg(0, 7'h08, 16'h0224, 16'h0900, 10'h0, 4'h3);
		pulse(4, 1);
		chk("offset out", {16'h0224, 16'h0}, u_dcs_far_model.per_log[2]);
	endtask
	task automatic t_prio;
		clr();
		// receive-only serial: second channel sends dummy transmit data from ram
		cfg(1, 7'h0A, 16'h0248, 16'h0020, 10'h0, 4'h3);
		cfg(0, 7'h0A, 16'h0248, 16'h0010, 10'h0, 4'h1);
		pulse(5, 1);
		chk("first", {16'h2010, 16'h0248 ^ 16'hC3C3}, u_dcs_far_model.ram_log[0]);
		chk("second", {16'h0248, 16'h2020 ^ 16'h3C3C}, u_dcs_far_model.per_log[0]);
		chk("both done", 32'h3, {24'h0, done});
	endtask
	task automatic t_count;
		clr();
		cfg(2, 7'h0D, 16'h0300, 16'h0040, 10'h2, 4'h5);
		pulse(8, 2);
		chk("not yet", 32'h0, {24'h0, done});
		pulse(8, 1);
		chk("done", 32'h4, {24'h0, done});
		chk("byte flag", 32'h1, {31'h0, xbyte});
		for (int k = 0; k < 3; k++) begin
			chk("byte step", 32'h2040 + k, {16'h0, u_dcs_far_model.ram_log[k][31:16]});
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		t_regs();
		t_codes();
		t_nocode();
		t_badpad();
		t_region();
		t_prio();
		t_count();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		$display("[ERR] watchdog expected end seen hang");
		finish_test();
	end
endmodule
